// >>> verilog/expander_pkg.sv
// Shared constants, state types and address decoding for the expander link
package expander_pkg;
    localparam logic [3:0] ADDR_FIXED = 4'h4;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] BIT_CNT_ONE = 4'h1;
    localparam logic [1:0] LAST_BYTE = 2'h2;
    localparam logic [15:0] PORT_RESET = 16'hFFFF;
    localparam logic [1:0] PH_DRIVE = 2'h0;
    localparam logic [1:0] PH_RISE = 2'h1;
    localparam logic [1:0] PH_SAMPLE = 2'h2;
    localparam logic [1:0] PH_FALL = 2'h3;
    localparam int MCLK_PERIOD_NS = 4;
    localparam int SCL_PERIOD_NS = 2500;
    localparam int SCL_QUARTER_CYCLES = SCL_PERIOD_NS / (4 * MCLK_PERIOD_NS);

    typedef enum logic [3:0] {
        DEV_IDLE = 4'h1,
        DEV_ADDR = 4'h2,
        DEV_WRITE = 4'h4,
        DEV_READ = 4'h8
    } dev_state_t;

    typedef enum logic [3:0] {
        M_IDLE = 4'h1,
        M_START = 4'h2,
        M_BIT = 4'h4,
        M_STOP = 4'h8
    } master_state_t;

    // Own address: fixed upper nibble, strapped select bits, direction last
    function automatic logic addrMatch(input logic [7:0] addrByte, input logic [2:0] sel);
        addrMatch = (addrByte[7:4] == ADDR_FIXED) && (addrByte[3:1] == sel);
    endfunction : addrMatch
endpackage : expander_pkg

// >>> verilog/expander_link_if.sv
// Two-wire link between the bus master end and the port expander end
`timescale 1ns/1ps
`default_nettype none
interface expander_link_if;
    logic scl;
    logic masterSdaOut;
    logic masterSdaOe;
    logic deviceSdaOut;
    logic deviceSdaOe;
    logic sda;

    // Wired-AND data line with pull-up
    assign sda = !((masterSdaOe && !masterSdaOut) || (deviceSdaOe && !deviceSdaOut));

    modport master_end (output scl, output masterSdaOut, output masterSdaOe, input sda);
    modport device_end (input scl, input sda, output deviceSdaOut, output deviceSdaOe);
endinterface : expander_link_if
`default_nettype wire

// >>> verilog/expander_device.sv
// Serial slave end of the 16-bit quasi-bidirectional port expander
//
// Link protocol rules this block works to
// - Master starts transfers only on idle bus
// - Start: SDA falls while SCL high
// - Address byte MSB first, direction bit last
// - General call address is never acknowledged
// - Matching address acknowledged low during ninth clock
// - Select straps stay steady during transactions
// - Read sends current port pin levels
// - Write latches only complete acknowledged bytes
// - Outputs change at acknowledge clock rising edge
// - One data bit per SCL pulse
// - SDA changes only while SCL low
// - Stop: SDA rises while SCL high
// - Eight bits then acknowledge; transmitter releases SDA
// - Every received byte acknowledged by device
// - Master acknowledges read bytes except last
// - Master ends read with not-acknowledge
// - Not-acknowledge makes device release SDA
// - Address 0100, then strapped select bits
// - Byte pairs: low port first, high second
// - Each completed pair replaces latched outputs
// - Reset sets all port lines weakly high
// - Master writes ones to input lines first
`timescale 1ns/1ps
`default_nettype none
module expander_device
    import expander_pkg::*;
(
    input wire logic rst,
    expander_link_if.device_end link,
    input wire logic [2:0] addressSelectPins,
    input wire logic [7:0] lowPortLinesIn,
    input wire logic [7:0] highPortLinesIn,
    output logic [7:0] lowPortLinesOut,
    output logic [7:0] lowPortLinesOe,
    output logic [7:0] highPortLinesOut,
    output logic [7:0] highPortLinesOe,
    output logic deviceSdaOut,
    output logic deviceSdaOe
);
    dev_state_t state;
    logic startTog;
    logic stopTog;
    logic startSeen;
    logic stopSeen;
    logic newStart;
    logic newStop;
    logic [3:0] bitCnt;
    logic [7:0] shiftIn;
    logic [7:0] lowHold;
    logic [7:0] txShift;
    logic byteHigh;
    logic [15:0] pinMeta;
    logic [15:0] pinSync;
    logic [2:0] selMeta;
    logic [2:0] selSync;

    // Ninth slot of each byte, where the acknowledge bit travels
    function automatic logic isAckSlot(input logic [3:0] cnt);
        isAckSlot = cnt == ACK_SLOT;
    endfunction : isAckSlot

    // Start marker: SDA falling while SCL high
    always_ff @(negedge link.sda or posedge rst) begin
        if (rst) begin
            startTog <= 1'b0;
        end else if (link.scl) begin
            startTog <= ~startTog;
        end
    end

    // Stop marker: SDA rising while SCL high
    always_ff @(posedge link.sda or posedge rst) begin
        if (rst) begin
            stopTog <= 1'b0;
        end else if (link.scl) begin
            stopTog <= ~stopTog;
        end
    end

    assign newStart = startTog != startSeen;
    assign newStop = stopTog != stopSeen;

    // Pin and strap synchronisers on the link clock
    always_ff @(posedge link.scl or posedge rst) begin
        if (rst) begin
            pinMeta <= PORT_RESET;
            pinSync <= PORT_RESET;
            selMeta <= 3'h0;
            selSync <= 3'h0;
        end else begin
            pinMeta <= {highPortLinesIn, lowPortLinesIn};
            pinSync <= pinMeta;
            selMeta <= addressSelectPins;
            selSync <= selMeta;
        end
    end

    // Protocol sequencer, one bit per rising SCL edge
    always_ff @(posedge link.scl or posedge rst) begin
        if (rst) begin
            state <= DEV_IDLE;
            startSeen <= 1'b0;
            stopSeen <= 1'b0;
            bitCnt <= 4'h0;
            shiftIn <= 8'h00;
            lowHold <= 8'hFF;
            txShift <= 8'hFF;
            byteHigh <= 1'b0;
        end else begin
            startSeen <= startTog;
            stopSeen <= stopTog;
            if (newStart) begin
                state <= DEV_ADDR;
                bitCnt <= BIT_CNT_ONE;
                shiftIn <= {7'h00, link.sda};
            end else if (newStop) begin
                state <= DEV_IDLE;
            end else if (bitCnt != ACK_SLOT) begin
                bitCnt <= 4'(bitCnt + 4'h1);
                shiftIn <= {shiftIn[6:0], link.sda};
                txShift <= {txShift[6:0], 1'b1};
            end else begin
                bitCnt <= 4'h0;
                case (state)
                    DEV_ADDR: begin
                        byteHigh <= 1'b0;
                        txShift <= pinSync[7:0];
                        if (!addrMatch(shiftIn, selSync)) begin
                            state <= DEV_IDLE;
                        end else if (shiftIn[0]) begin
                            state <= DEV_READ;
                        end else begin
                            state <= DEV_WRITE;
                        end
                    end
                    DEV_WRITE: begin
                        byteHigh <= ~byteHigh;
                        if (!byteHigh) begin
                            lowHold <= shiftIn;
                        end
                    end
                    DEV_READ: begin
                        if (link.sda) begin
                            state <= DEV_IDLE;
                        end else begin
                            byteHigh <= ~byteHigh;
                            txShift <= byteHigh ? pinSync[7:0] : pinSync[15:8];
                        end
                    end
                    default: begin
                        state <= DEV_IDLE;
                    end
                endcase
            end
        end
    end

    // Output latches, updated at the acknowledge clock of the second byte
    always_ff @(posedge link.scl or posedge rst) begin
        if (rst) begin
            lowPortLinesOut <= PORT_RESET[7:0];
            highPortLinesOut <= PORT_RESET[15:8];
            lowPortLinesOe <= ~PORT_RESET[7:0];
            highPortLinesOe <= ~PORT_RESET[15:8];
        end else if (state == DEV_WRITE && !newStart && !newStop
                     && isAckSlot(bitCnt) && byteHigh) begin
            lowPortLinesOut <= lowHold;
            highPortLinesOut <= shiftIn;
            lowPortLinesOe <= ~lowHold;
            highPortLinesOe <= ~shiftIn;
        end
    end

    // Data line driver, changed only on falling SCL
    always_ff @(negedge link.scl or posedge rst) begin
        if (rst) begin
            deviceSdaOut <= 1'b0;
            deviceSdaOe <= 1'b0;
        end else if (newStart || newStop) begin
            deviceSdaOut <= 1'b0;
            deviceSdaOe <= 1'b0;
        end else begin
            deviceSdaOut <= 1'b0;
            case (state)
                DEV_ADDR: begin
                    deviceSdaOe <= isAckSlot(bitCnt) && addrMatch(shiftIn, selSync);
                end
                DEV_WRITE: begin
                    deviceSdaOe <= isAckSlot(bitCnt);
                end
                DEV_READ: begin
                    deviceSdaOe <= !isAckSlot(bitCnt) && !txShift[7];
                end
                default: begin
                    deviceSdaOe <= 1'b0;
                end
            endcase
        end
    end
endmodule : expander_device
`default_nettype wire

// >>> verilog/expander_master.sv
// Bus master end: one two-byte write or read per command
`timescale 1ns/1ps
`default_nettype none
module expander_master
    import expander_pkg::*;
#(
    parameter int QUARTER = SCL_QUARTER_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    expander_link_if.master_end link,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic cmdRead,
    input wire logic [2:0] cmdSelect,
    input wire logic [15:0] cmdData,
    output logic rspValid,
    output logic [15:0] rspData,
    output logic rspNack,
    output logic scl,
    output logic masterSdaOut,
    output logic masterSdaOe
);
    master_state_t state;
    logic [15:0] tickCnt;
    logic tick;
    logic [1:0] phase;
    logic [3:0] bitCnt;
    logic [1:0] byteCnt;
    logic [7:0] txByte;
    logic [15:0] data;
    logic [15:0] rxShift;
    logic readOp;
    logic nack;
    logic sdaMeta;
    logic sdaSync;

    // Quarter-period tick from the divider
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tickCnt <= 16'h0000;
            tick <= 1'b0;
        end else if (tickCnt == 16'(QUARTER - 1)) begin
            tickCnt <= 16'h0000;
            tick <= 1'b1;
        end else begin
            tickCnt <= 16'(tickCnt + 16'h0001);
            tick <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sdaMeta <= 1'b1;
            sdaSync <= 1'b1;
        end else begin
            sdaMeta <= link.sda;
            sdaSync <= sdaMeta;
        end
    end

    // Transfer sequencer, also drives the link pins
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= M_IDLE;
            cmdReady <= 1'b1;
            rspValid <= 1'b0;
            rspData <= 16'h0000;
            rspNack <= 1'b0;
            scl <= 1'b1;
            masterSdaOut <= 1'b0;
            masterSdaOe <= 1'b0;
            phase <= PH_DRIVE;
            bitCnt <= 4'h0;
            byteCnt <= 2'h0;
            txByte <= 8'h00;
            data <= 16'h0000;
            rxShift <= 16'h0000;
            readOp <= 1'b0;
            nack <= 1'b0;
        end else begin
            rspValid <= 1'b0;
            case (state)
                M_IDLE: begin
                    if (cmdValid && cmdReady) begin
                        cmdReady <= 1'b0;
                        readOp <= cmdRead;
                        data <= cmdData;
                        txByte <= {ADDR_FIXED, cmdSelect, cmdRead};
                        nack <= 1'b0;
                        phase <= PH_DRIVE;
                        state <= M_START;
                    end
                end
                M_START: begin
                    if (tick) begin
                        phase <= 2'(phase + 2'h1);
                        if (phase == PH_DRIVE) begin
                            masterSdaOe <= 1'b1;
                        end else begin
                            scl <= 1'b0;
                            phase <= PH_DRIVE;
                            bitCnt <= 4'h0;
                            byteCnt <= 2'h0;
                            state <= M_BIT;
                        end
                    end
                end
                M_BIT: begin
                    if (tick) begin
                        phase <= 2'(phase + 2'h1);
                        case (phase)
                            PH_DRIVE: begin
                                if (bitCnt == ACK_SLOT) begin
                                    masterSdaOe <= readOp && byteCnt == 2'h1;
                                end else begin
                                    masterSdaOe <= (byteCnt == 2'h0 || !readOp) && !txByte[7];
                                end
                            end
                            PH_RISE: begin
                                scl <= 1'b1;
                            end
                            PH_SAMPLE: begin
                                if (bitCnt == ACK_SLOT) begin
                                    if (byteCnt == 2'h0 || !readOp) begin
                                        nack <= sdaSync;
                                    end
                                end else if (readOp && byteCnt != 2'h0) begin
                                    rxShift <= {rxShift[14:0], sdaSync};
                                end
                            end
                            default: begin
                                scl <= 1'b0;
                                if (bitCnt == ACK_SLOT) begin
                                    bitCnt <= 4'h0;
                                    byteCnt <= 2'(byteCnt + 2'h1);
                                    txByte <= (byteCnt == 2'h0) ? data[7:0] : data[15:8];
                                    if (nack || byteCnt == LAST_BYTE) begin
                                        state <= M_STOP;
                                    end
                                end else begin
                                    bitCnt <= 4'(bitCnt + 4'h1);
                                    txByte <= {txByte[6:0], 1'b1};
                                end
                            end
                        endcase
                    end
                end
                M_STOP: begin
                    if (tick) begin
                        phase <= 2'(phase + 2'h1);
                        case (phase)
                            PH_DRIVE: masterSdaOe <= 1'b1;
                            PH_RISE: scl <= 1'b1;
                            PH_SAMPLE: masterSdaOe <= 1'b0;
                            default: begin
                                rspValid <= 1'b1;
                                rspNack <= nack;
                                rspData <= {rxShift[7:0], rxShift[15:8]};
                                cmdReady <= 1'b1;
                                state <= M_IDLE;
                            end
                        endcase
                    end
                end
                default: begin
                    state <= M_IDLE;
                end
            endcase
        end
    end
endmodule : expander_master
`default_nettype wire

// >>> verification/expander_link_assertions.sv
// Checker watching the two-wire link and the expander port outputs
`timescale 1ns/1ps
`default_nettype none
module expander_link_assertions
    import expander_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic masterSdaOe,
    input wire logic deviceSdaOe,
    input wire logic [2:0] addressSelectPins,
    input wire logic [7:0] lowPortLinesOut,
    input wire logic [7:0] lowPortLinesOe,
    input wire logic [7:0] highPortLinesOut,
    input wire logic [7:0] highPortLinesOe
);
    logic [5:0] riseCnt;
    logic [7:0] addrByte;
    logic rdDir;
    logic nackSeen;

    // Bit slot count since the last start, address shift and read direction
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            riseCnt <= 6'h00;
            addrByte <= 8'h00;
            rdDir <= 1'b0;
            nackSeen <= 1'b0;
        end else if (scl && $fell(sda)) begin
            riseCnt <= 6'h00;
            addrByte <= 8'h00;
            rdDir <= 1'b0;
            nackSeen <= 1'b0;
        end else if ($rose(scl)) begin
            riseCnt <= riseCnt + 6'h01;
            if (riseCnt < 6'h08) begin
                addrByte <= {addrByte[6:0], sda};
            end
            if (riseCnt == 6'h07) begin
                rdDir <= sda;
            end
            if (rdDir && riseCnt > 6'h09 && riseCnt % 6'h09 == 6'h08 && sda) begin
                nackSeen <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence sclRise;
        $rose(scl);
    endsequence
    sequence ackSlot;
        sclRise ##0 (riseCnt % 6'h09 == 6'h08);
    endsequence

    start_by_master_a: assert property (
        scl && $fell(sda) |-> masterSdaOe && !deviceSdaOe) else $error("bad start");
    dev_sda_lowscl_a: assert property (
        $changed(deviceSdaOe) |-> !scl) else $error("device sda moved with scl high");
    sda_held_high_a: assert property (
        deviceSdaOe && scl |=> deviceSdaOe || !scl) else $error("device sda dropped early");
    addr_ack_a: assert property (
        ackSlot ##0 (riseCnt == 6'h08) |-> deviceSdaOe ==
        (addrByte[7:4] == ADDR_FIXED && addrByte[3:1] == addressSelectPins))
        else $error("address ack wrong");
    wr_ack_only_a: assert property (
        sclRise ##0 (deviceSdaOe && !rdDir) |-> riseCnt % 6'h09 == 6'h08)
        else $error("device drove a write data bit");
    wr_ack_each_a: assert property (
        ackSlot ##0 (!rdDir && riseCnt > 6'h08) |-> deviceSdaOe) else $error("byte not acked");
    rd_release_a: assert property (
        ackSlot ##0 (rdDir && riseCnt > 6'h09) |-> !deviceSdaOe) else $error("no release");
    nack_release_a: assert property (
        nackSeen |-> !deviceSdaOe) else $error("device drives after nack");
    port_at_ack_a: assert property (
        $changed({highPortLinesOut, lowPortLinesOut}) |->
        $rose(scl) && !rdDir && riseCnt % 6'h12 == 6'h08) else $error("port changed off slot");
    oe_tracks_latch_a: assert property (
        1'b1 |-> {highPortLinesOe, lowPortLinesOe} == ~{highPortLinesOut, lowPortLinesOut})
        else $error("drive enable wrong");
    scl_pulse_a: assert property (
        sclRise |-> scl[*4]) else $error("scl pulse short");
    stop_release_a: assert property (
        scl && $rose(sda) |-> !deviceSdaOe) else $error("device holds sda at stop");
endmodule : expander_link_assertions
`default_nettype wire

// >>> verification/i2c_port_expander_slave_tb_top.sv
// Testbench joining the master end and the expander end over the link
`timescale 1ns/1ps
`default_nettype none
module i2c_port_expander_slave_tb_top;
    import expander_pkg::*;
    typedef struct packed {
        logic nack;
        logic rd;
        logic [15:0] data;
    } note_t;
    note_t expQ[$];
    logic mclk = 1'b0;
    logic rst = 1'b0;
    logic cmdValid = 1'b0;
    logic cmdRead = 1'b0;
    logic [2:0] cmdSelect = 3'h0;
    logic [15:0] cmdData = 16'h0000;
    logic [2:0] addressSelectPins = 3'h5;
    logic [15:0] extPins = 16'hFFFF;
    logic cmdReady, rspValid, rspNack, scl, masterSdaOut, masterSdaOe;
    logic deviceSdaOut, deviceSdaOe;
    logic [15:0] rspData;
    logic [7:0] lowPortLinesOut, lowPortLinesOe, highPortLinesOut, highPortLinesOe;
    logic [7:0] lowIn, highIn;
    int errors = 0;
    int nTests = 0;

    expander_link_if link ();
    always #2 mclk = ~mclk;
    assign link.scl = scl;
    assign link.masterSdaOut = masterSdaOut;
    assign link.masterSdaOe = masterSdaOe;
    assign link.deviceSdaOut = deviceSdaOut;
    assign link.deviceSdaOe = deviceSdaOe;
    // Quasi pins: a driven-low line reads low, otherwise the outside level
    assign lowIn = extPins[7:0] & ~lowPortLinesOe;
    assign highIn = extPins[15:8] & ~highPortLinesOe;

    expander_master #(.QUARTER(4)) i_expander_master (
        .mclk(mclk), .rst(rst), .link(link), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .cmdRead(cmdRead), .cmdSelect(cmdSelect), .cmdData(cmdData), .rspValid(rspValid),
        .rspData(rspData), .rspNack(rspNack), .scl(scl), .masterSdaOut(masterSdaOut),
        .masterSdaOe(masterSdaOe));
    expander_device i_expander_device (
        .rst(rst), .link(link), .addressSelectPins(addressSelectPins),
        .lowPortLinesIn(lowIn), .highPortLinesIn(highIn),
        .lowPortLinesOut(lowPortLinesOut), .lowPortLinesOe(lowPortLinesOe),
        .highPortLinesOut(highPortLinesOut), .highPortLinesOe(highPortLinesOe),
        .deviceSdaOut(deviceSdaOut), .deviceSdaOe(deviceSdaOe));
    expander_link_assertions i_expander_link_assertions (
        .mclk(mclk), .rst(rst), .scl(link.scl), .sda(link.sda),
        .masterSdaOe(link.masterSdaOe), .deviceSdaOe(link.deviceSdaOe),
        .addressSelectPins(addressSelectPins),
        .lowPortLinesOut(lowPortLinesOut), .lowPortLinesOe(lowPortLinesOe),
        .highPortLinesOut(highPortLinesOut), .highPortLinesOe(highPortLinesOe));

    task automatic check(input logic [15:0] got, input logic [15:0] want);
        nTests++;
        if (got !== want) begin
            errors++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, want);
        end
    endtask : check

    task automatic reportAndStop();
        $display("comparisons %0d mismatches %0d", nTests, errors);
        if (errors == 0 && nTests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : reportAndStop

    // One command, noted in the queue, then a bounded wait for its answer
    task automatic doCmd(input logic rd, input logic [2:0] sel, input logic [15:0] d,
                         input note_t e);
        int n;
        expQ.push_back(e);
        @(posedge mclk);
        #1;
        cmdValid = 1'b1;
        cmdRead = rd;
        cmdSelect = sel;
        cmdData = d;
        @(posedge mclk);
        #1;
        cmdValid = 1'b0;
        n = 0;
        while (rspValid !== 1'b1 && n < 2000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (rspValid !== 1'b1) begin
            errors++;
            reportAndStop();
        end else begin
            check({15'h0000, cmdReady}, 16'h0001);
        end
    endtask : doCmd

    always @(negedge mclk) begin
        note_t e;
        if (rspValid === 1'b1) begin
            if (expQ.size() == 0) begin
                check(16'h0001, 16'h0000);
            end else begin
                e = expQ.pop_front();
                check({15'h0000, rspNack}, {15'h0000, e.nack});
                if (!e.nack && e.rd) begin
                    check(rspData, e.data);
                end
            end
        end
    end

    initial begin
        logic [15:0] d;
        void'($urandom(32'hBCFE));
        extPins = 16'($urandom);
        #1;
        rst = 1'b1;
        repeat (12) @(posedge mclk);
        #1;
        rst = 1'b0;
        doCmd(1'b0, 3'h2, 16'h1234, '{1'b1, 1'b0, 16'h0000});
        check({highPortLinesOut, lowPortLinesOut}, PORT_RESET);
        check({highPortLinesOe, lowPortLinesOe}, 16'h0000);
        $display("test dummy frame done");
        for (int s = 0; s < 8; s++) begin
            addressSelectPins = 3'(s);
            d = (s == 7) ? 16'hFFFF : ((s == 6) ? 16'h0000 : 16'($urandom));
            doCmd(1'b0, 3'(s), d, '{1'b0, 1'b0, 16'h0000});
            check({highPortLinesOut, lowPortLinesOut}, d);
            check({highPortLinesOe, lowPortLinesOe}, ~d);
            extPins = 16'($urandom);
            doCmd(1'b1, 3'(s), 16'h0000, '{1'b0, 1'b1, extPins & d});
            doCmd(1'b1, 3'(s) ^ 3'h4, 16'h0000, '{1'b1, 1'b1, 16'h0000});
            $display("test select %0d done", s);
        end
        doCmd(1'b0, 3'h7, 16'hA50F, '{1'b0, 1'b0, 16'h0000});
        check({highPortLinesOut, lowPortLinesOut}, 16'hA50F);
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        rst = 1'b0;
        check({highPortLinesOut, lowPortLinesOut}, PORT_RESET);
        d = 16'($urandom);
        doCmd(1'b0, 3'h7, d, '{1'b0, 1'b0, 16'h0000});
        check({highPortLinesOut, lowPortLinesOut}, d);
        $display("test second reset done");
        reportAndStop();
    end
endmodule : i2c_port_expander_slave_tb_top
`default_nettype wire
